// >>> cptg_pkg.sv
package cptg_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CPTG_CTRL_ADDR = 8'h00;
    localparam logic [7:0] CPTG_DELAY_ADDR = 8'h04;
    localparam logic [7:0] CPTG_HIGH_ADDR = 8'h08;
    localparam logic [7:0] CPTG_LOW_ADDR = 8'h0C;
    localparam logic [7:0] CPTG_COUNT_ADDR = 8'h10;
    localparam logic [7:0] CPTG_STATUS_ADDR = 8'h14;
    localparam logic [7:0] CPTG_FIFO_ADDR = 8'h18;
    localparam logic [7:0] CPTG_DONE_ADDR = 8'h1C;

    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int CPTG_CTRL_ARM = 0;
    localparam int CPTG_CTRL_MODE_LO = 1;
    localparam int CPTG_CTRL_FALL = 4;
    localparam int CPTG_CTRL_TRIG = 5;
    localparam int CPTG_CTRL_PAUSE = 6;
    localparam int CPTG_CTRL_RETRIG = 7;
    localparam int CPTG_CTRL_DLY_ALL = 8;
    localparam int CPTG_CTRL_REGEN = 9;
    localparam int CPTG_CTRL_FIN = 10;
    localparam int CPTG_CTRL_PAUSE_HI = 11;

    // ------------------------------------------------------------
    // modes, states, sizes, resets
    // ------------------------------------------------------------
    localparam logic [2:0] CPTG_MODE_SINGLE = 3'h0;
    localparam logic [2:0] CPTG_MODE_FINITE = 3'h1;
    localparam logic [2:0] CPTG_MODE_CONT = 3'h2;
    localparam logic [2:0] CPTG_MODE_IMPL = 3'h3;
    localparam logic [2:0] CPTG_MODE_SCLK = 3'h4;

    localparam int CPTG_W = 32;
    localparam int CPTG_FIFO_DEPTH = 16;
    localparam int CPTG_FIFO_AW = 4;
    localparam logic [31:0] CPTG_CTRL_RST = 32'h00000000;
    localparam logic [31:0] CPTG_ONE = 32'h00000001;

    // largest count a sample idle width may effectively hold
    localparam logic [15:0] CPTG_HALF_MASK = 16'hFFFF;

    typedef enum logic [4:0] {
        CPTG_IDLE = 5'b00001,
        CPTG_WAIT = 5'b00010,
        CPTG_DELAY = 5'b00100,
        CPTG_LOW = 5'b01000,
        CPTG_HIGH = 5'b10000
    } cptg_state_t;

endpackage

// >>> cptg_sync.sv
`timescale 1ns/1ns
`default_nettype none
// two-stage synchroniser with edge outputs on the settled level
module cptg_sync
    import cptg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta;
    logic last;

    // ------------------------------------------------------------
    // capture
    // ------------------------------------------------------------
    // first stage read only by the second
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            meta <= 1'b0;
            level <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= pin;
            level <= meta;
            last <= level;
        end
    end

    // edge strobes
    assign rise = level & ~last;
    assign fall = ~level & last;
endmodule // cptg_sync
`default_nettype wire

// >>> cptg_top.sv
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - after arm, wait delay ticks, then output high for width ticks
// - start-trigger single mode times delay from one trigger, emits one pulse
// - finite train: pulse counter halts generator at programmed count
// - retrigger mode: every gate trigger while waiting launches new pulse or train
// - option applies initial delay to first trigger only or every trigger
// - gate ignored during generation; then wait for next trigger
// - retrigger mode never allows pause on the gate
// - continuous: delay after arm, then alternate high and low widths
// - continuous train starts at arm or at gate trigger
// - gate as pause trigger suspends generation while active
// - continuous frequency equals tick frequency over high plus low
// - implicit buffered: each fifo sample sets next pulse idle/active
// - sample-clocked: samples update timing at sample clock edges
// - implicit buffered ignores channel settings; pulses equal samples
// - sample-clocked uses channel settings until first sample clock
// - finite implicit: one pulse per pair, back to back, then stop
// - continuous implicit keeps pulsing from samples until stopped
// - sample clock lets current pulse finish before new specs apply
// - finite sample-clocked keeps last sample's specs until stopped
// - regeneration replays loaded fifo; host writes none afterwards
// - non-regeneration continuous buffered flags underflow when data runs out
module cptg_top
    import cptg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic tick_in,
    input wire logic gate_in,
    input wire logic sample_clk_in,
    output logic pulse_out,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    logic [31:0] ctrl, delay_cnt, high_w, low_w, pulse_cnt;
    logic [31:0] fifo_mem [CPTG_FIFO_DEPTH];
    logic [CPTG_FIFO_AW:0] wr_ptr, rd_ptr, fill;
    logic underflow, done;
    cptg_state_t state, next_state;
    logic [31:0] phase_cnt, emitted;
    logic [15:0] cur_idle, cur_act;
    logic have_sample, first_done;
    logic aw_held, w_held, wr_fire, wr_ctrl, rd_done;
    logic [7:0] aw_addr;
    logic [31:0] w_data;

    logic tick_r, tick_f, gate_lvl, gate_r, sclk_r;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    cptg_sync u_tick (.ref_clk(ref_clk), .reset(reset), .pin(tick_in),
        .level(), .rise(tick_r), .fall(tick_f));
    cptg_sync u_gate (.ref_clk(ref_clk), .reset(reset), .pin(gate_in),
        .level(gate_lvl), .rise(gate_r), .fall());
    cptg_sync u_sclk (.ref_clk(ref_clk), .reset(reset), .pin(sample_clk_in),
        .level(), .rise(sclk_r), .fall());

    // ------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------
    wire armed = ctrl[CPTG_CTRL_ARM];
    wire [2:0] mode = ctrl[CPTG_CTRL_MODE_LO +: 3];
    wire use_trig = ctrl[CPTG_CTRL_TRIG];
    wire retrig = ctrl[CPTG_CTRL_RETRIG];
    wire dly_all = ctrl[CPTG_CTRL_DLY_ALL];
    wire regen = ctrl[CPTG_CTRL_REGEN];
    wire fin = ctrl[CPTG_CTRL_FIN];
    wire tick = ctrl[CPTG_CTRL_FALL] ? tick_f : tick_r;
    wire is_impl = (mode == CPTG_MODE_IMPL);
    wire is_sclk = (mode == CPTG_MODE_SCLK);
    wire buffered = is_impl | is_sclk;
    wire pause_en = ctrl[CPTG_CTRL_PAUSE] & ~use_trig & ~retrig;
    wire paused = pause_en & (gate_lvl == ctrl[CPTG_CTRL_PAUSE_HI]);
    wire trig_ok = (state == CPTG_WAIT) & gate_r;
    wire step = tick & ~paused;
    wire fifo_empty = (fill == '0);
    wire [31:0] fifo_head = fifo_mem[rd_ptr[CPTG_FIFO_AW-1:0]];

    // active widths depend on mode: channel regs or current sample
    wire [31:0] w_low = (buffered & have_sample) ? {16'h0000, cur_idle} : low_w;
    wire [31:0] w_high = (buffered & have_sample) ? {16'h0000, cur_act} : high_w;
    wire phase_end = step & (phase_cnt + CPTG_ONE >= ((state == CPTG_DELAY) ? delay_cnt :
        (state == CPTG_LOW) ? w_low : w_high));

    // sample fetch point at end of each high phase
    wire pulse_end = (state == CPTG_HIGH) & phase_end;
    wire count_hit = (emitted + CPTG_ONE >= pulse_cnt);
    wire impl_stop = is_impl & fin & fifo_empty & ~regen;
    wire single = (mode == CPTG_MODE_SINGLE);
    wire train_over = single | ((mode == CPTG_MODE_FINITE) & count_hit) | impl_stop;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            CPTG_IDLE: begin
                // a finished generation stays idle until disarmed
                if (armed & ~first_done) begin
                    next_state = (use_trig | retrig) ? CPTG_WAIT :
                        (is_impl ? CPTG_LOW : CPTG_DELAY);
                end
            end
            CPTG_WAIT: begin
                // delay from trigger; initial delay choice
                if (trig_ok) begin
                    next_state = (~first_done | dly_all) ? CPTG_DELAY : CPTG_LOW;
                end
            end
            CPTG_DELAY: begin
                if (phase_end) begin
                    next_state = CPTG_HIGH;
                end
            end
            CPTG_LOW: begin
                if (phase_end) begin
                    next_state = CPTG_HIGH;
                end
            end
            CPTG_HIGH: begin
                if (phase_end) begin
                    if (train_over) begin
                        next_state = retrig ? CPTG_WAIT : CPTG_IDLE;
                    end else begin
                        next_state = CPTG_LOW;
                    end
                end
            end
            default: next_state = CPTG_IDLE;
        endcase
        if (!armed) begin
            next_state = CPTG_IDLE;
        end
    end

    // ------------------------------------------------------------
    // generator registers
    // ------------------------------------------------------------
    // counters frozen on pause since step is gated
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state <= CPTG_IDLE;
            phase_cnt <= '0;
        end else begin
            state <= next_state;
            if (next_state != state) begin
                phase_cnt <= '0;
            end else if (step) begin
                phase_cnt <= phase_cnt + CPTG_ONE;
            end
        end
    end

    // output high only in high phase
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pulse_out <= 1'b0;
        end else begin
            pulse_out <= (next_state == CPTG_HIGH);
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            emitted <= '0;
            first_done <= 1'b0;
            done <= 1'b0;
        end else begin
            if ((state == CPTG_IDLE) | trig_ok) begin
                emitted <= '0;
            end else if (pulse_end) begin
                emitted <= emitted + CPTG_ONE;
            end
            if (~armed) begin
                first_done <= 1'b0;
            end else if (pulse_end) begin
                first_done <= 1'b1;
            end
            // done is hardware-set, set wins over clear
            if (pulse_end & train_over) begin
                done <= 1'b1;
            end else if (rd_done) begin
                done <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // sample fifo
    // ------------------------------------------------------------
    // pop per pulse; sample clock only marks a pop, taken at pulse end
    logic sclk_pend;
    wire load_pt = is_impl ? ((state == CPTG_IDLE & armed & ~first_done) | pulse_end)
        : (sclk_pend & (pulse_end | ~have_sample & state == CPTG_IDLE));
    wire pop = buffered & load_pt & ~fifo_empty;
    // underflow when a sample is needed and none is there
    wire starve = buffered & load_pt & fifo_empty & ~regen & ~(is_impl & fin)
        & (state != CPTG_IDLE) & ~(is_sclk & fin);
    wire push = wr_fire & (aw_addr == CPTG_FIFO_ADDR) & (~armed | ~regen)
        & (fill != CPTG_FIFO_DEPTH[CPTG_FIFO_AW:0]);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end else begin
            // host writes blocked while armed in regeneration
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                // replay: read pointer wraps back to the first loaded word
                rd_ptr <= (regen & (rd_ptr + 1'b1 == wr_ptr)) ? wr_ptr - fill : rd_ptr + 1'b1;
            end
            // regeneration keeps the loaded set counted while it replays
            fill <= fill + {4'h0, push} - {4'h0, pop & ~regen};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            fifo_mem[wr_ptr[CPTG_FIFO_AW-1:0]] <= w_data;
        end
    end

    // current sample held until the next one
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cur_idle <= '0;
            cur_act <= '0;
            have_sample <= 1'b0;
            sclk_pend <= 1'b0;
            underflow <= 1'b0;
        end else begin
            if (pop) begin
                cur_idle <= fifo_head[31:16] & CPTG_HALF_MASK;
                cur_act <= fifo_head[15:0];
                have_sample <= 1'b1;
            end else if (~armed) begin
                have_sample <= 1'b0;
            end
            // sample clock noted until a sample pops at a pulse end, or until disarm
            if (is_sclk & sclk_r & armed) begin
                sclk_pend <= 1'b1;
            end else if (pop | ~armed) begin
                sclk_pend <= 1'b0;
            end
            // sticky error, set wins over clear
            if (starve) begin
                underflow <= 1'b1;
            end else if (wr_ctrl) begin
                underflow <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
    assign wr_ctrl = wr_fire & (aw_addr == CPTG_CTRL_ADDR);
    assign rd_done = s_axi_arvalid & s_axi_arready & (s_axi_araddr == CPTG_DONE_ADDR);
    wire wr_ok = (aw_addr <= CPTG_FIFO_ADDR) & (aw_addr[1:0] == 2'b00)
        & (aw_addr != CPTG_STATUS_ADDR);
    assign s_axi_awready = ~aw_held;
    assign s_axi_wready = ~w_held;
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            if (s_axi_awvalid & ~aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & ~w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // config registers; full-word writes assumed by strobe
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctrl <= CPTG_CTRL_RST;
            delay_cnt <= '0;
            high_w <= '0;
            low_w <= '0;
            pulse_cnt <= '0;
        end else if (wr_fire & (s_axi_wstrb == 4'hF)) begin
            case (aw_addr)
                CPTG_CTRL_ADDR: ctrl <= w_data;
                CPTG_DELAY_ADDR: delay_cnt <= w_data;
                CPTG_HIGH_ADDR: high_w <= w_data;
                CPTG_LOW_ADDR: low_w <= w_data;
                CPTG_COUNT_ADDR: pulse_cnt <= w_data;
                default: ;
            endcase
        end
    end

    // read mux
    wire [31:0] status = {19'h0, fill, done, underflow, pulse_out, state};
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid & ~s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= (s_axi_araddr <= CPTG_DONE_ADDR) ? 2'b00 : 2'b10;
            case (s_axi_araddr)
                CPTG_CTRL_ADDR: s_axi_rdata <= ctrl;
                CPTG_DELAY_ADDR: s_axi_rdata <= delay_cnt;
                CPTG_HIGH_ADDR: s_axi_rdata <= high_w;
                CPTG_LOW_ADDR: s_axi_rdata <= low_w;
                CPTG_COUNT_ADDR: s_axi_rdata <= pulse_cnt;
                CPTG_STATUS_ADDR: s_axi_rdata <= status;
                CPTG_DONE_ADDR: s_axi_rdata <= {31'h0, done};
                default: s_axi_rdata <= '0;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_pause_hold;
        @(posedge ref_clk) disable iff (reset)
        paused & armed & (state == $past(state)) |=> (pulse_out == $past(pulse_out));
    endproperty
    a_pause_hold: assert property (p_pause_hold) else $error("pause moved output");

    property p_no_pause_retrig;
        @(posedge ref_clk) disable iff (reset)
        retrig & armed & tick & (state == CPTG_DELAY) & ~phase_end
        |=> (phase_cnt == $past(phase_cnt) + CPTG_ONE);
    endproperty
    a_no_pause_retrig: assert property (p_no_pause_retrig) else $error("pause in retrigger");

    property p_gate_ignored;
        @(posedge ref_clk) disable iff (reset)
        (state != CPTG_WAIT) & (state != CPTG_IDLE) & gate_r & armed & ~phase_end
        |=> (state == $past(state));
    endproperty
    a_gate_ignored: assert property (p_gate_ignored) else $error("gate taken mid pulse");

    property p_high_out;
        @(posedge ref_clk) disable iff (reset) (state == CPTG_HIGH) |-> pulse_out;
    endproperty
    a_high_out: assert property (p_high_out) else $error("output low in high phase");

    property p_trig_start;
        @(posedge ref_clk) disable iff (reset)
        trig_ok & armed & dly_all |=> (state == CPTG_DELAY);
    endproperty
    a_trig_start: assert property (p_trig_start) else $error("trigger not taken");

    property p_underflow;
        @(posedge ref_clk) disable iff (reset) starve |=> underflow;
    endproperty
    a_underflow: assert property (p_underflow) else $error("underflow not flagged");

    property p_finite_stop;
        @(posedge ref_clk) disable iff (reset)
        pulse_end & (mode == CPTG_MODE_FINITE) & count_hit & ~retrig & armed
        |=> (state == CPTG_IDLE) ##1 ~pulse_out;
    endproperty
    a_finite_stop: assert property (p_finite_stop) else $error("finite train ran on");

    property p_single_once;
        @(posedge ref_clk) disable iff (reset)
        pulse_end & single & ~retrig & armed |=> (state == CPTG_IDLE);
    endproperty
    a_single_once: assert property (p_single_once) else $error("extra single pulse");

    c_pulse: cover property (@(posedge ref_clk) disable iff (reset) pulse_end);
    c_pop: cover property (@(posedge ref_clk) disable iff (reset) pop);
    c_trig: cover property (@(posedge ref_clk) disable iff (reset) trig_ok);
endmodule // cptg_top
`default_nettype wire

// >>> cptg_far.sv
`timescale 1ns/1ns
`default_nettype none
// far side: free tick source and a start-trigger line
module cptg_far
    import cptg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic fire,
    output logic tick_in,
    output logic gate_in
);
    logic [2:0] div;
    logic [4:0] hold;
    // ------------------------------------------------------------
    // tick and trigger
    // ------------------------------------------------------------
    // tick stalls after trigger
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            div <= 3'h0;
            hold <= 5'h00;
        end else begin
            hold <= fire ? 5'h14 : hold - {4'h0, hold != 5'h00};
            div <= div + {2'h0, hold == 5'h00};
        end
    end
    // tick period of eight clocks; a stall keeps two and a half periods clear
    assign tick_in = div[2];
    assign gate_in = hold > 5'h0C;
endmodule // cptg_far
`default_nettype wire

// >>> counter_pulse_train_generator_tb.sv
`timescale 1ns/1ns
`default_nettype none
module counter_pulse_train_generator_tb
    import cptg_pkg::*;
;
    localparam int TP = 8;
    logic ref_clk, reset, fire, pulse_out, tick_in, gate_in, sclk;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    int err_count, checked, cyc;
    // ------------------------------------------------------------
    // design and far side
    // ------------------------------------------------------------
    cptg_top cptg_top_inst (.ref_clk(ref_clk), .reset(reset), .tick_in(tick_in),
        .gate_in(gate_in), .sample_clk_in(sclk), .pulse_out(pulse_out),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    cptg_far cptg_far_inst (.ref_clk(ref_clk), .reset(reset), .fire(fire),
        .tick_in(tick_in), .gate_in(gate_in));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // hang guard, well above the expected run
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            summarize();
        end
    end
    task automatic summarize();
        if (err_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // bus tasks sample ready 1 ns after each edge, release right after the next one
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic pa, pw, ta, tw, got;
        @(posedge ref_clk);
        {pa, pw, got} = 3'b110;
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        while (pa || pw || !got) begin
            #1;
            ta = pa && awready;
            tw = pw && wready;
            got = bvalid;
            @(posedge ref_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic pa, ta, got;
        @(posedge ref_clk);
        {pa, got} = 2'b10;
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        while (pa || !got) begin
            #1;
            ta = pa && arready;
            got = rvalid;
            d = rdata;
            r = rresp;
            @(posedge ref_clk);
            if (ta) arvalid <= 1'b0;
            pa = pa && !ta;
        end
        rready <= 1'b0;
    endtask
    // cycles for which the output keeps one level
    task automatic run_len(input logic lvl, output int n);
        n = 0;
        #1;
        while (pulse_out === lvl && n < 3000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask
    task automatic rises(input int win, output int n);
        logic prev;
        n = 0;
        prev = pulse_out;
        repeat (win) begin
            @(posedge ref_clk);
            #1;
            if (pulse_out === 1'b1 && prev === 1'b0) n++;
            prev = pulse_out;
        end
    endtask
    task automatic trig();
        @(posedge ref_clk);
        fire <= 1'b1;
        @(posedge ref_clk);
        fire <= 1'b0;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        rd(CPTG_CTRL_ADDR, d, r);
        chk(d, CPTG_CTRL_RST);
        rd(8'h20, d, r);
        chk({30'h0, r}, 32'h2);
    endtask
    task automatic t_single();
        int n, hi;
        wr(CPTG_DELAY_ADDR, 32'h4);
        wr(CPTG_HIGH_ADDR, 32'h3);
        for (int f = 0; f < 2; f++) begin
            wr(CPTG_CTRL_ADDR, 32'h1 | (f << CPTG_CTRL_FALL));
            run_len(1'b0, n);
            chk(n > 2 * TP && n < 5 * TP, 1);
            run_len(1'b1, hi);
            chk(hi, 3 * TP);
            rises(200, n);
            chk(n, 0);
            wr(CPTG_CTRL_ADDR, 32'h0);
        end
    endtask
    task automatic t_trains();
        int n, hi, lo;
        wr(CPTG_HIGH_ADDR, 32'h2);
        wr(CPTG_LOW_ADDR, 32'h3);
        wr(CPTG_CTRL_ADDR, 32'h45);
        rises(200, n);
        chk(n, 0);
        wr(CPTG_CTRL_ADDR, 32'h5);
        run_len(1'b0, n);
        run_len(1'b1, hi);
        run_len(1'b0, lo);
        chk(hi, 2 * TP);
        chk(hi + lo, 5 * TP);
        rises(400, n);
        chk(n, 10);
        wr(CPTG_CTRL_ADDR, 32'h0);
        wr(CPTG_COUNT_ADDR, 32'h4);
        wr(CPTG_CTRL_ADDR, 32'h3);
        rises(600, n);
        chk(n, 4);
        wr(CPTG_CTRL_ADDR, 32'h0);
    endtask
    task automatic t_trig();
        int n;
        wr(CPTG_HIGH_ADDR, 32'h3);
        wr(CPTG_CTRL_ADDR, 32'h1A1);
        rises(100, n);
        chk(n, 0);
        for (int i = 0; i < 2; i++) begin
            trig();
            rises(30, n);
            trig();
            rises(150, n);
            chk(n, 1);
        end
        wr(CPTG_CTRL_ADDR, 32'h0);
    endtask
    task automatic t_impl();
        logic [31:0] smp [3] = '{32'h00020002, 32'h00030004, 32'h00020002};
        int n, hi;
        wr(CPTG_HIGH_ADDR, 32'h9);
        for (int i = 0; i < 3; i++) wr(CPTG_FIFO_ADDR, smp[i]);
        wr(CPTG_CTRL_ADDR, 32'h407);
        for (int i = 0; i < 3; i++) begin
            run_len(1'b0, n);
            if (i > 0) chk(n, smp[i][31:16] * TP);
            run_len(1'b1, hi);
            chk(hi, smp[i][15:0] * TP);
        end
        rises(200, n);
        chk(n, 0);
        wr(CPTG_CTRL_ADDR, 32'h0);
    endtask
    task automatic t_sclk();
        int n, hi;
        wr(CPTG_FIFO_ADDR, 32'h00010002);
        wr(CPTG_CTRL_ADDR, 32'h409);
        run_len(1'b0, n);
        run_len(1'b1, hi);
        chk(hi, 9 * TP);
        @(posedge ref_clk);
        sclk <= 1'b1;
        repeat (4) @(posedge ref_clk);
        sclk <= 1'b0;
        run_len(1'b0, n);
        for (int i = 0; i < 3; i++) begin
            run_len(1'b1, hi);
            chk(hi, (i > 0 ? 2 : 9) * TP);
            run_len(1'b0, n);
        end
        chk(n, TP);
        wr(CPTG_CTRL_ADDR, 32'h0);
    endtask
    task automatic t_fifo();
        logic [31:0] d;
        logic [1:0] r;
        int n;
        wr(CPTG_FIFO_ADDR, 32'h00010001);
        wr(CPTG_CTRL_ADDR, 32'h007);
        rises(200, n);
        rd(CPTG_STATUS_ADDR, d, r);
        chk(d[6], 1);
        wr(CPTG_CTRL_ADDR, 32'h0);
        wr(CPTG_FIFO_ADDR, 32'h00020002);
        wr(CPTG_FIFO_ADDR, 32'h00020002);
        wr(CPTG_CTRL_ADDR, 32'h207);
        rises(100, n);
        rises(320, n);
        chk(n, 10);
        rd(CPTG_STATUS_ADDR, d, r);
        chk(d[6], 0);
        wr(CPTG_CTRL_ADDR, 32'h0);
    endtask
    initial begin
        reset = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, fire, sclk} = 7'h00;
        {awaddr, araddr, wdata} = 48'h0;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        t_regs();
        t_single();
        t_trains();
        t_trig();
        t_impl();
        t_sclk();
        t_fifo();
        summarize();
    end
endmodule // counter_pulse_train_generator_tb
`default_nettype wire
